// ### isp_port_ctrl.sv
// Test port controller with programming, user store and pin clamp
`timescale 1ns/100ps
module isp_port_ctrl
#(
   parameter int          NUM_PINS      = 8,
   parameter int          CONFIG_CYCLES = isp_pkg::CONFIG_CYCLES,
   parameter logic [3:0]  ID_VERSION    = 4'h1,     // Arbitrary value
   parameter logic [15:0] ID_PART       = 16'h5A3C, // Arbitrary value
   parameter logic [10:0] ID_MAKER      = 11'h2B5   // Arbitrary value
)
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Test port pins
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   output logic                       tdo,
   output logic                       tdo_oe,
   // Device pins
   input  wire logic [NUM_PINS-1:0]   pin_in,
   output logic      [NUM_PINS-1:0]   pin_out,
   output logic      [NUM_PINS-1:0]   pin_oe,
   output logic      [NUM_PINS-1:0]   pin_pullup,
   // Array side of the pins
   input  wire logic [NUM_PINS-1:0]   user_pin_out,
   input  wire logic [NUM_PINS-1:0]   user_pin_oe,
   output logic      [NUM_PINS-1:0]   user_pin_in,
   // Array side of the user chains
   output logic                       chain_tck,
   output logic                       chain_tms,
   output logic                       chain_tdi,
   output logic [3:0]                 chain_state,
   output logic                       chain_sel_first,
   output logic                       chain_sel_second,
   output logic                       chain_capture,
   output logic                       chain_shift,
   output logic                       chain_update,
   input  wire logic                  chain_tdo_first,
   input  wire logic                  chain_tdo_second,
   // Array side of the user store
   input  wire logic [8:0]            unv_addr,
   input  wire logic [15:0]           unv_wdata,
   input  wire logic                  unv_program,
   input  wire logic                  unv_erase,
   input  wire logic                  unv_sector,
   output logic      [15:0]           unv_rdata,
   output logic                       unv_busy,
   // Configuration image and status
   output logic [isp_pkg::CFG_WORDS*16-1:0] config_image,
   output logic                       user_mode,
   output logic                       program_complete_flag,
   // Register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata
);
   localparam int CW = $clog2(CONFIG_CYCLES + 1);
   localparam int NW = NUM_PINS + 3;

   typedef struct packed {
      isp_pkg::tap_state_t tap;
      isp_pkg::cfg_state_t cfg;
      logic [CW-1:0]       cnt;
      logic [7:0]          ir;
      logic [7:0]          ir_sr;
      logic [31:0]         sr;
      logic                tck_q;
      logic                tdo;
      logic                tdo_oe;
      logic                isp;
      logic                armed;
      logic                done;
      logic [NUM_PINS-1:0] cl_val;
      logic [NUM_PINS-1:0] cl_oe;
      logic [2*NUM_PINS-1:0] cl_mode;
      logic [NUM_PINS-1:0] p_out;
      logic [NUM_PINS-1:0] p_oe;
      logic [NUM_PINS-1:0] p_pu;
      logic [8:0]          u_addr;
      logic [15:0]         u_rd;
      logic [3:0]          busy_cnt;
      logic                erasing;
      logic                er_sect;
      logic [7:0]          er_cnt;
      logic [isp_pkg::CFG_WORDS-1:0][15:0] image;
      logic [31:0]         rdata;
      logic [8:0]          chain;
   } st_t;

   st_t s;
   st_t next_s;

   logic [NW-1:0] sync_q;
   logic          tck_s;
   logic          tms_s;
   logic          tdi_s;
   logic          rise;
   logic          fall;
   logic          act1;
   logic          act2;
   int            len;
   logic [31:0]   cap;
   logic [31:0]   upd;
   logic [15:0]   cfg_mem [isp_pkg::CFG_WORDS];
   logic [15:0]   unv_mem [isp_pkg::UNV_WORDS];
   logic          cfg_we;
   logic [2:0]    cfg_wa;
   logic [15:0]   cfg_wd;
   logic          unv_we;
   logic [8:0]    unv_wa;
   logic [15:0]   unv_wd;

   // Controller step for one rising test clock
   function automatic isp_pkg::tap_state_t tap_next(
      input isp_pkg::tap_state_t st,
      input logic m);
      case (st)
         isp_pkg::TAP_RESET:  tap_next = m ? st : isp_pkg::TAP_IDLE;
         isp_pkg::TAP_IDLE:   tap_next = m ? isp_pkg::TAP_SEL_DR : st;
         isp_pkg::TAP_SEL_DR:
            tap_next = m ? isp_pkg::TAP_SEL_IR : isp_pkg::TAP_CAP_DR;
         isp_pkg::TAP_CAP_DR, isp_pkg::TAP_SHF_DR:
            tap_next = m ? isp_pkg::TAP_EX1_DR : isp_pkg::TAP_SHF_DR;
         isp_pkg::TAP_EX1_DR:
            tap_next = m ? isp_pkg::TAP_UPD_DR : isp_pkg::TAP_PAU_DR;
         isp_pkg::TAP_PAU_DR: tap_next = m ? isp_pkg::TAP_EX2_DR : st;
         isp_pkg::TAP_EX2_DR:
            tap_next = m ? isp_pkg::TAP_UPD_DR : isp_pkg::TAP_SHF_DR;
         isp_pkg::TAP_SEL_IR:
            tap_next = m ? isp_pkg::TAP_RESET : isp_pkg::TAP_CAP_IR;
         isp_pkg::TAP_CAP_IR, isp_pkg::TAP_SHF_IR:
            tap_next = m ? isp_pkg::TAP_EX1_IR : isp_pkg::TAP_SHF_IR;
         isp_pkg::TAP_EX1_IR:
            tap_next = m ? isp_pkg::TAP_UPD_IR : isp_pkg::TAP_PAU_IR;
         isp_pkg::TAP_PAU_IR: tap_next = m ? isp_pkg::TAP_EX2_IR : st;
         isp_pkg::TAP_EX2_IR:
            tap_next = m ? isp_pkg::TAP_UPD_IR : isp_pkg::TAP_SHF_IR;
         default:
            tap_next = m ? isp_pkg::TAP_SEL_DR : isp_pkg::TAP_IDLE;
      endcase
   endfunction

   // Data register length for each instruction
   function automatic int dr_len(input logic [7:0] code);
      case (code)
         isp_pkg::IR_IDCODE:   dr_len = isp_pkg::SR_W;
         isp_pkg::IR_CLAMP:    dr_len = 2 * NUM_PINS;
         isp_pkg::IR_CFG_PROG: dr_len = isp_pkg::CFG_AW + isp_pkg::DW;
         isp_pkg::IR_UNV_PROG,
         isp_pkg::IR_UNV_READ: dr_len = isp_pkg::UNV_AW + isp_pkg::DW;
         default:              dr_len = 1;
      endcase
   endfunction

   // Test pins and device pins pass two flops first
   signal_sync #(.WIDTH(NW)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       ({pin_in, tck, tms, tdi}),
      .q       (sync_q)
   );

   assign tck_s = sync_q[2];
   assign tms_s = sync_q[1];
   assign tdi_s = sync_q[0];
   assign user_pin_in = sync_q[NW-1:3];
   assign rise = tck_s & ~s.tck_q;
   assign fall = ~tck_s & s.tck_q;
   assign act1 = (s.ir == isp_pkg::IR_CHAIN_FIRST);
   assign act2 = (s.ir == isp_pkg::IR_CHAIN_SECND);
   assign len = dr_len(s.ir);
   assign upd = s.sr >> (isp_pkg::SR_W - len);

   // Capture sources for the shared data register
   always_comb
   begin
      cap = '0;
      case (s.ir)
         isp_pkg::IR_IDCODE:
            cap = {ID_VERSION, ID_PART, ID_MAKER, isp_pkg::ID_LSB};
         isp_pkg::IR_UNV_READ:
            cap = 32'({s.u_addr, unv_mem[s.u_addr]});
         isp_pkg::IR_CLAMP: cap = 32'(s.cl_mode);
         default: cap = '0;
      endcase
   end

   // Store write ports; arrays hold no reset as flash keeps its contents
   always_ff @(posedge clk_sys)
   begin
      if (cfg_we)
         cfg_mem[cfg_wa] <= cfg_wd;
      if (unv_we)
         unv_mem[unv_wa] <= unv_wd;
   end

   always_comb
   begin
      next_s = s;
      cfg_we = 1'b0;
      cfg_wa = upd[18:16];
      cfg_wd = upd[15:0];
      unv_we = 1'b0;
      unv_wa = unv_addr;
      unv_wd = unv_wdata;
      next_s.tck_q = tck_s;
      next_s.u_rd = unv_mem[unv_addr];
      if (s.busy_cnt != 4'h0)
         next_s.busy_cnt = s.busy_cnt - 4'h1;

      // Erase walks one word per cycle so the store needs one write port
      if (s.erasing)
      begin
         unv_we = 1'b1;
         unv_wa = {s.er_sect, s.er_cnt};
         unv_wd = isp_pkg::UNV_ERASED;
         next_s.er_cnt = s.er_cnt + 8'h01;
         next_s.erasing = (s.er_cnt != 8'hFF);
      end
      else if (!unv_busy && unv_program)
      begin
         unv_we = 1'b1;
         next_s.busy_cnt = isp_pkg::UNV_PROG_CY;
      end
      else if (!unv_busy && unv_erase)
      begin
         next_s.erasing = 1'b1;
         next_s.er_sect = unv_sector;
         next_s.er_cnt = 8'h00;
      end

      // Test port, sampled on the rising test clock
      if (rise)
      begin
         next_s.tap = tap_next(s.tap, tms_s);
         case (s.tap)
            isp_pkg::TAP_RESET: next_s.ir = isp_pkg::IR_IDCODE;
            isp_pkg::TAP_CAP_IR: next_s.ir_sr = isp_pkg::IR_CAPTURE;
            isp_pkg::TAP_SHF_IR: next_s.ir_sr = {tdi_s, s.ir_sr[7:1]};
            isp_pkg::TAP_CAP_DR:
               next_s.sr = cap << (isp_pkg::SR_W - len);
            isp_pkg::TAP_SHF_DR: next_s.sr = {tdi_s, s.sr[31:1]};
            isp_pkg::TAP_UPD_IR:
            begin
               next_s.ir = s.ir_sr;
               case (s.ir_sr)
                  isp_pkg::IR_ISP_ENTER:
                     next_s.isp = (s.cfg == isp_pkg::CFG_USER);
                  isp_pkg::IR_ISP_EXIT:
                  begin
                     next_s.isp = 1'b0;
                     next_s.armed = 1'b0;
                  end
                  isp_pkg::IR_RELOAD:
                     if (s.isp)
                     begin
                        next_s.cfg = isp_pkg::CFG_LOAD;
                        next_s.cnt = '0;
                        next_s.isp = 1'b0;
                        next_s.armed = 1'b0;
                     end
                  default: ;
               endcase
            end
            isp_pkg::TAP_UPD_DR:
               case (s.ir)
                  isp_pkg::IR_CLAMP:
                  begin
                     next_s.cl_mode = upd[2*NUM_PINS-1:0];
                     next_s.cl_val = s.p_out;
                     next_s.cl_oe = s.p_oe;
                     next_s.armed = 1'b1;
                  end
                  isp_pkg::IR_CFG_ERASE:
                     if (s.isp)
                        next_s.done = 1'b0;
                  isp_pkg::IR_CFG_PROG:
                     cfg_we = s.isp;
                  isp_pkg::IR_DONE_PROG:
                     if (s.isp)
                        next_s.done = 1'b1;
                  isp_pkg::IR_UNV_READ:
                     next_s.u_addr = upd[24:16];
                  isp_pkg::IR_UNV_PROG:
                     if (s.isp && !s.erasing)
                     begin
                        unv_we = 1'b1;
                        unv_wa = upd[24:16];
                        unv_wd = upd[15:0];
                        next_s.u_addr = upd[24:16];
                        next_s.busy_cnt = isp_pkg::UNV_PROG_CY;
                     end
                  isp_pkg::IR_UNV_ERASE:
                     if (s.isp && !s.erasing)
                     begin
                        next_s.erasing = 1'b1;
                        next_s.er_sect = upd[0];
                        next_s.er_cnt = 8'h00;
                     end
                  default: ;
               endcase
            default: ;
         endcase
      end

      // Output bit changes on the falling test clock
      if (fall)
      begin
         next_s.tdo_oe = (s.tap == isp_pkg::TAP_SHF_DR) ||
                         (s.tap == isp_pkg::TAP_SHF_IR);
         if (s.tap == isp_pkg::TAP_SHF_IR)
            next_s.tdo = s.ir_sr[0];
         else if (act1)
            next_s.tdo = chain_tdo_first;
         else if (act2)
            next_s.tdo = chain_tdo_second;
         else
            next_s.tdo = s.sr[isp_pkg::SR_W - len];
      end

      // Port and state reach the array only under a user chain
      next_s.chain = {tck_s, tms_s, tdi_s, act1, act2,
                      next_s.tap == isp_pkg::TAP_CAP_DR,
                      next_s.tap == isp_pkg::TAP_SHF_DR,
                      next_s.tap == isp_pkg::TAP_UPD_DR, 1'b0};
      if (!(act1 || act2))
         next_s.chain = '0;

      // Power-up load copies the store, then waits out the load time
      if (s.cfg == isp_pkg::CFG_LOAD)
      begin
         if (s.cnt < CW'(isp_pkg::CFG_WORDS))
            next_s.image[s.cnt[2:0]] = cfg_mem[s.cnt[2:0]];
         next_s.cnt = s.cnt + CW'(1);
         if (s.cnt == CW'(CONFIG_CYCLES - 1))
            next_s.cfg = isp_pkg::CFG_USER;
      end

      // Software reload takes the same path as the commanded one
      if (reg_wr && reg_addr == isp_pkg::REG_CTRL &&
          reg_wdata[isp_pkg::CTRL_RELOAD])
      begin
         next_s.cfg = isp_pkg::CFG_LOAD;
         next_s.cnt = '0;
         next_s.isp = 1'b0;
         next_s.armed = 1'b0;
      end

      // Pin control, safest condition first
      for (int i = 0; i < NUM_PINS; i++)
      begin
         next_s.p_out[i] = 1'b0;
         next_s.p_oe[i] = 1'b0;
         next_s.p_pu[i] = 1'b1;
         if (s.cfg == isp_pkg::CFG_LOAD || !s.done)
            next_s.p_oe[i] = 1'b0;
         else if (s.armed && (s.isp || s.ir == isp_pkg::IR_CLAMP))
         begin
            next_s.p_pu[i] = 1'b0;
            case (s.cl_mode[2*i +: 2])
               isp_pkg::CLAMP_HOLD:
               begin
                  next_s.p_out[i] = s.cl_val[i];
                  next_s.p_oe[i] = s.cl_oe[i];
               end
               isp_pkg::CLAMP_HIGH:
               begin
                  next_s.p_out[i] = 1'b1;
                  next_s.p_oe[i] = 1'b1;
               end
               isp_pkg::CLAMP_LOW: next_s.p_oe[i] = 1'b1;
               default: next_s.p_oe[i] = 1'b0;
            endcase
         end
         else if (s.isp)
            next_s.p_oe[i] = 1'b0;
         else
         begin
            next_s.p_out[i] = user_pin_out[i];
            next_s.p_oe[i] = user_pin_oe[i];
            next_s.p_pu[i] = 1'b0;
         end
      end

      // Register reads answer one cycle later, zero elsewhere
      next_s.rdata = '0;
      if (reg_rd && reg_addr == isp_pkg::REG_STATUS)
      begin
         next_s.rdata[isp_pkg::ST_DONE] = s.done;
         next_s.rdata[isp_pkg::ST_ISP] = s.isp;
         next_s.rdata[isp_pkg::ST_LOAD] = (s.cfg == isp_pkg::CFG_LOAD);
         next_s.rdata[isp_pkg::ST_ARMED] = s.armed;
         next_s.rdata[isp_pkg::ST_BUSY] = unv_busy;
         next_s.rdata[isp_pkg::ST_TAP +: 4] = s.tap;
      end
   end

   // All state in one register; stores survive reset by design
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s <= '0;
         s.tap <= isp_pkg::TAP_RESET;
         s.cfg <= isp_pkg::CFG_LOAD;
         s.ir <= isp_pkg::IR_IDCODE;
         s.done <= isp_pkg::DONE_RST;
         s.p_pu <= '1;
      end
      else
         s <= next_s;
   end

   // Outputs straight from state
   assign tdo = s.tdo;
   assign tdo_oe = s.tdo_oe;
   assign pin_out = s.p_out;
   assign pin_oe = s.p_oe;
   assign pin_pullup = s.p_pu;
   assign chain_tck = s.chain[8];
   assign chain_tms = s.chain[7];
   assign chain_tdi = s.chain[6];
   assign chain_sel_first = s.chain[5];
   assign chain_sel_second = s.chain[4];
   assign chain_capture = s.chain[3];
   assign chain_shift = s.chain[2];
   assign chain_update = s.chain[1];
   assign chain_state = s.chain[5] | s.chain[4] ? s.tap : 4'h0;
   assign unv_rdata = s.u_rd;
   assign unv_busy = s.erasing | (s.busy_cnt != 4'h0);
   assign config_image = s.image;
   assign user_mode = (s.cfg == isp_pkg::CFG_USER);
   assign program_complete_flag = s.done;
   assign reg_rdata = s.rdata;
endmodule

// ### isp_pkg.sv
// Constants for the test port, programming and pin clamp block
package isp_pkg;
   // Instruction register and codes
   localparam int         IR_W           = 8;
   localparam logic [7:0] IR_CAPTURE     = 8'h01;
   localparam logic [7:0] IR_BYPASS      = 8'hFF;
   localparam logic [7:0] IR_IDCODE      = 8'h06;
   localparam logic [7:0] IR_CHAIN_FIRST = 8'h0C;
   localparam logic [7:0] IR_CHAIN_SECND = 8'h0E;
   localparam logic [7:0] IR_ISP_ENTER   = 8'h2C;
   localparam logic [7:0] IR_ISP_EXIT    = 8'h3D;
   localparam logic [7:0] IR_CLAMP       = 8'h2D;
   localparam logic [7:0] IR_CFG_ERASE   = 8'hF2;
   localparam logic [7:0] IR_CFG_PROG    = 8'hF4;
   localparam logic [7:0] IR_DONE_PROG   = 8'hF8;
   localparam logic [7:0] IR_UNV_PROG    = 8'hF5;
   localparam logic [7:0] IR_UNV_READ    = 8'hF6;
   localparam logic [7:0] IR_UNV_ERASE   = 8'hF3;
   localparam logic [7:0] IR_RELOAD      = 8'h63;
   localparam logic       ID_LSB         = 1'b1;
   // Stores
   localparam int          SR_W        = 32;
   localparam int          CFG_AW      = 3;
   localparam int          CFG_WORDS   = 8;
   localparam int          DW          = 16;
   localparam int          UNV_AW      = 9;
   localparam int          UNV_WORDS   = 512;
   localparam int          SECT_AW     = 8;
   localparam logic [15:0] UNV_ERASED  = 16'hFFFF;
   localparam logic [3:0]  UNV_PROG_CY = 4'h8;
   // Power-up load time
   localparam int CLK_MHZ        = 200;
   localparam int CONFIG_TIME_US = 300;
   localparam int CONFIG_CYCLES  = CONFIG_TIME_US * CLK_MHZ;
   // Clamp modes per pin
   localparam logic [1:0] CLAMP_HOLD = 2'h0;
   localparam logic [1:0] CLAMP_HIGH = 2'h1;
   localparam logic [1:0] CLAMP_LOW  = 2'h2;
   localparam logic [1:0] CLAMP_TRI  = 2'h3;
   // Register port
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int         CTRL_RELOAD = 0;
   localparam int         ST_DONE    = 0;
   localparam int         ST_ISP     = 1;
   localparam int         ST_LOAD    = 2;
   localparam int         ST_ARMED   = 3;
   localparam int         ST_BUSY    = 4;
   localparam int         ST_TAP     = 8;
   localparam logic       DONE_RST   = 1'b1;
   // Test port controller states
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3,
      TAP_CAP_DR = 4'h2, TAP_SHF_DR = 4'h6, TAP_EX1_DR = 4'h7,
      TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4, TAP_UPD_DR = 4'hC,
      TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SHF_IR = 4'hE,
      TAP_EX1_IR = 4'hA, TAP_PAU_IR = 4'hB, TAP_EX2_IR = 4'h9,
      TAP_UPD_IR = 4'h8
   } tap_state_t;
   // Configuration phase
   typedef enum logic {CFG_LOAD = 1'b0, CFG_USER = 1'b1} cfg_state_t;
endpackage

// ### signal_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module signal_sync
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Async in, synced out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t s;
   sync_t next_s;

   // First stage feeds only the second
   always_comb
   begin
      next_s.meta = d;
      next_s.stable = s.meta;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign q = s.stable;
endmodule

// ### isp_chk.sv
// Checker for the test port block, bound to its ports
`timescale 1ns/100ps
module isp_chk
#(
   parameter int NUM_PINS = 8
)
(
   // Clock and reset
   input wire logic                clk_sys,
   input wire logic                rst,
   // Array side of the user chains
   input wire logic                chain_tck,
   input wire logic [3:0]          chain_state,
   input wire logic                chain_sel_first,
   input wire logic                chain_sel_second,
   input wire logic                chain_capture,
   input wire logic                chain_shift,
   input wire logic                chain_update,
   // Pins and status
   input wire logic [NUM_PINS-1:0] pin_oe,
   input wire logic [NUM_PINS-1:0] pin_pullup,
   input wire logic                user_mode,
   input wire logic                program_complete_flag,
   // Register port
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Array sees nothing of the port unless a chain is chosen
   a_chain_gated: assert property (
      !(chain_sel_first | chain_sel_second) |->
      chain_state == 4'h0 && !chain_tck) else $error("chain port leak");
   a_chain_single: assert property (
      !(chain_sel_first && chain_sel_second)) else $error("two chains");
   a_shift_state: assert property (
      chain_shift |-> chain_state == isp_pkg::TAP_SHF_DR)
      else $error("shift flag off state");
   a_capture_state: assert property (
      chain_capture |-> chain_state == isp_pkg::TAP_CAP_DR)
      else $error("capture flag off state");
   a_update_state: assert property (
      chain_update |-> chain_state == isp_pkg::TAP_UPD_DR)
      else $error("update flag off state");
   // Pins float with pull-ups for the whole load
   a_load_float: assert property (
      !user_mode |=> pin_oe == '0 && pin_pullup == '1)
      else $error("pin driven while loading");
   a_load_hold: assert property (
      $fell(user_mode) |-> !user_mode [*8]) else $error("load too short");
   a_undone_float: assert property (
      !program_complete_flag |=> pin_oe == '0)
      else $error("pin driven before done");
   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 32'h0) else $error("read data unasked");
   cover property ($rose(user_mode));
   cover property (chain_shift && chain_sel_second);
   cover property ($fell(program_complete_flag));
endmodule

// ### jtag_prog.sv
// Programmer model driving the four-wire test port
`timescale 1ns/100ps
module jtag_prog
(
   // Clock and port
   input  wire logic clk_sys,
   input  wire logic tdo,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One port clock of 125 ns; tck rests low between frames
   task automatic tick(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      repeat (12) @(posedge clk_sys);
      o = tdo;
      tck <= 1'b1;
      repeat (13) @(posedge clk_sys);
      tck <= 1'b0;
   endtask
   // Whole scan from Idle back to Idle, LSB first
   task automatic scan(input logic ir, input logic [31:0] v,
                       input int n, output logic [31:0] o);
      logic x;
      o = 32'h0;
      @(posedge clk_sys);
      tick(1'b0, ~tdi, x);
      tick(1'b1, ~tdi, x);
      if (ir)
         tick(1'b1, ~tdi, x);
      tick(1'b0, ~tdi, x);
      tick(1'b0, ~tdi, x);
      for (int i = 0; i < n; i++)
         tick(i == n - 1, v[i], o[i]);
      tick(1'b1, ~tdi, x);
      tick(1'b0, ~tdi, x);
   endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the test port block
`timescale 1ns/100ps
module tb_top;
   logic         clk_sys, rst, tck, tms, tdi, tdo, sel_a, sel_b;
   logic [7:0]   pin_out, pin_oe, pin_pullup, reg_addr;
   logic [7:0]   pin_in, upi, user_out, user_oe;
   logic [31:0]  reg_wdata, reg_rdata, rv, sd;
   logic         reg_wr, reg_rd, user_mode, done;
   logic         ctdo1, ctdo2, unv_program, unv_busy;
   logic [8:0]   unv_addr;
   logic [15:0]  unv_rdata, unv_wdata;
   logic [127:0] config_image, ci;
   int           failures = 0;
   int           check_count = 0;
   isp_port_ctrl #(.CONFIG_CYCLES(32), .ID_VERSION(4'h1),
      .ID_PART(16'h5A3C), .ID_MAKER(11'h2B5)) DUT (
      .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup(pin_pullup), .user_pin_out(user_out),
      .user_pin_oe(user_oe), .user_pin_in(upi), .chain_tck(), .chain_tms(),
      .chain_tdi(), .chain_state(), .chain_sel_first(sel_a),
      .chain_sel_second(sel_b), .chain_capture(), .chain_shift(),
      .chain_update(), .chain_tdo_first(ctdo1), .chain_tdo_second(ctdo2),
      .unv_addr(unv_addr), .unv_wdata(unv_wdata), .unv_program(unv_program),
      .unv_erase(1'b0), .unv_sector(1'b0), .unv_rdata(unv_rdata),
      .unv_busy(unv_busy), .config_image(config_image), .user_mode(user_mode),
      .program_complete_flag(done), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   jtag_prog u_prog (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tms(tms),
      .tdi(tdi));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Register accesses start just after an edge
   task automatic rw(input logic wr, input logic [7:0] a);
      @(posedge clk_sys);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= 32'h1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic sc(input logic ir, input logic [31:0] v, input int n);
      u_prog.scan(ir, v, n, sd);
   endtask
   // Bounded wait for the load to finish
   task automatic wait_mode();
      int k;
      k = 0;
      while (user_mode !== 1'b1 && k < 200)
      begin
         @(posedge clk_sys);
         k++;
      end
      chk(user_mode, 1'b1);
   endtask
   // Main sequence; programmer waits for user mode first
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      pin_in = 8'h3C;
      user_out = 8'hA5;
      user_oe = 8'hFF;
      {ctdo1, ctdo2, unv_program} = 3'b100;
      unv_addr = 9'h005;
      unv_wdata = 16'h0000;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      wait_mode();
      sc(1'b0, 32'h0, 32);
      chk(sd, {4'h1, 16'h5A3C, 11'h2B5, 1'b1});
      rw(1'b0, isp_pkg::REG_STATUS);
      chk(rv[1:0], 2'b01);
      chk(upi, 8'h3C);
      sc(1'b1, isp_pkg::IR_CHAIN_FIRST, 8);
      chk({sel_a, sel_b}, 2'b10);
      sc(1'b0, 32'h0, 4);
      chk(sd, 32'hF);
      sc(1'b1, isp_pkg::IR_CHAIN_SECND, 8);
      chk({sel_a, sel_b}, 2'b01);
      sc(1'b0, 32'hF, 4);
      chk(sd, 32'h0);
      chk({pin_oe, pin_out}, 16'hFFA5);
      sc(1'b1, isp_pkg::IR_ISP_ENTER, 8);
      chk({pin_oe, pin_pullup}, 16'h00FF);
      ci = config_image;
      sc(1'b1, isp_pkg::IR_UNV_PROG, 8);
      sc(1'b0, {7'h0, 9'h005, 16'hBEEF}, 25);
      chk(unv_rdata, 16'hBEEF);
      chk(config_image === ci, 1'b1);
      // Array-side write holds busy through its program time
      unv_wdata <= 16'h1357;
      unv_program <= 1'b1;
      @(posedge clk_sys);
      unv_program <= 1'b0;
      #1 chk(unv_busy, 1'b1);
      repeat (9) @(posedge clk_sys);
      chk({unv_busy, unv_rdata}, 17'h01357);
      sc(1'b1, isp_pkg::IR_CFG_ERASE, 8);
      sc(1'b0, 32'h0, 1);
      sc(1'b1, isp_pkg::IR_CFG_PROG, 8);
      sc(1'b0, 32'h1234, 19);
      chk(done, 1'b0);
      sc(1'b1, isp_pkg::IR_ISP_EXIT, 8);
      chk(pin_oe, 8'h00);
      sc(1'b1, isp_pkg::IR_ISP_ENTER, 8);
      sc(1'b1, isp_pkg::IR_DONE_PROG, 8);
      sc(1'b0, 32'h0, 1);
      chk(done, 1'b1);
      // Clamp samples the user drive, then holds it into programming
      sc(1'b1, isp_pkg::IR_ISP_EXIT, 8);
      sc(1'b1, isp_pkg::IR_CLAMP, 8);
      sc(1'b0, 32'hFFE4, 16);
      sc(1'b1, isp_pkg::IR_ISP_ENTER, 8);
      chk({pin_oe, pin_out[2:0]}, {8'h07, 3'h3});
      sc(1'b1, isp_pkg::IR_ISP_EXIT, 8);
      chk({pin_oe, pin_out}, 16'hFFA5);
      rw(1'b1, isp_pkg::REG_CTRL);
      repeat (3) @(posedge clk_sys);
      chk({user_mode, pin_oe}, 9'h000);
      wait_mode();
      chk(config_image[15:0], 16'h1234);
      rw(1'b0, 8'h10);
      chk(rv, 32'h0);
      results();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      #200000;
      failures++;
      results();
   end
endmodule
bind isp_port_ctrl isp_chk #(.NUM_PINS(NUM_PINS)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .chain_tck(chain_tck),
   .chain_state(chain_state), .chain_sel_first(chain_sel_first),
   .chain_sel_second(chain_sel_second), .chain_capture(chain_capture),
   .chain_shift(chain_shift), .chain_update(chain_update),
   .pin_oe(pin_oe), .pin_pullup(pin_pullup), .user_mode(user_mode),
   .program_complete_flag(program_complete_flag), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata));
